/* rtl/dma_ctrl.sv */
/*
  Four-channel DMA control: reload registers, start requests, transfer sequencing,
  terminal count, NMI interruption, forced termination and AXI4-Lite registers.
  Assumes request and NMI pins are asynchronous; memory bus and triggers share core_clk.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Writes between transfers update both master and working copies.
// - A transfer ends on terminal count or on a written abort bit.
// - Values written during a transfer move to working copies when it ends.
// - Writes before a transfer starts overwrite both copies; software checks start.
// - The active-low request pin is sampled as a level every clock.
// - Pin requests count only with enable set and terminal count clear.
// - Software trigger starts a transfer with enable set and count flag clear.
// - Selected peripheral interrupt starts a transfer when enabled and flag clear.
// - Selected USB request starts a transfer, in single mode only.
// - Terminal count pulses one clock, the clock after the cycle strobe.
// - Pulse at the write cycle start, or the flyby cycle start.
// - NMI clears every enable; acknowledged once the engine is idle after the current unit's write, with the transfer left unfinished.
// - The abort bit forcibly terminates that channel's transfer.
// - A request is answered no sooner than four clocks.
// - Accesses take at least two clocks; two clocks separate read and write.
// - Block mode pays the response time once, then repeats read, gap, write, or the write alone in flyby.
// - For 16 and 32-bit transfers the address LSB is forced to zero.
// - DMA holds off the CPU while it owns the bus.
// - During a transfer writes reach only the master; reads show the working copy.
// - Channel 0 has the highest priority and channel 3 the lowest.
// - Setting the terminal count flag raises the transfer-end interrupt.
module dma_ctrl
  import dma_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int NPERIPH = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // AXI4-Lite register port.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Channel pins.
  input wire logic [NUM_CH-1:0] xfer_request_pin_n,
  output logic [NUM_CH-1:0] xfer_ack_pin_n,
  output logic [NUM_CH-1:0] terminal_count_n,
  // Other start sources.
  input wire logic [NPERIPH-1:0] periph_irq,
  input wire logic usb_req,
  // NMI.
  input wire logic nmi_in,
  output logic nmi_ack,
  // System bus.
  output mem_bus_s mem_out,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ready,
  output logic bus_cycle_start_strobe_n,
  output logic cpu_hold,
  // Interrupt controller.
  output logic [NUM_CH-1:0] transfer_end_interrupt
);
  // Channel state.
  logic [NUM_CH-1:0] en_reg, stg_reg, tc_reg, block_reg, flyby_reg, run_reg, irq_reg;
  logic [1:0] size_reg [NUM_CH];
  logic [7:0] trig_reg [NUM_CH];
  logic [31:0] src_q [NUM_CH];
  logic [31:0] dst_q [NUM_CH];
  logic [CNT_W-1:0] cnt_q [NUM_CH];
  // Synchronisers.
  logic [NUM_CH-1:0] req_s1_reg, req_s2_reg;
  logic nmi_s1_reg, nmi_s2_reg, nmi_s3_reg, nmi_pend_reg, nmi_ack_reg;
  // Engine.
  dma_state_e state_reg;
  logic [1:0] cur_reg;
  logic [2:0] wait_reg;
  logic [31:0] data_reg;
  mem_bus_s mem_out_reg;
  logic strobe_n_reg, hold_reg;
  logic [NUM_CH-1:0] ack_n_reg, tc_n_reg;
  // AXI state.
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  // Combinational terms.
  logic wr_fire, wr_hit;
  logic [32:0] wr_cur;
  logic [31:0] wval, wmask;
  logic [7:0] act;
  logic [NUM_CH-1:0] wr_src, wr_dst, wr_cnt, wr_ctl, wr_trg;
  logic [NUM_CH-1:0] pend, accept, abort_wr, tc_set, end_ev, step;
  logic [1:0] grant;
  logic grant_ok, wait0, acc_done, last_cur, cont, flyc, wr_end, abort_cur, go_rd, go_wr, nmi_rise;

  function automatic logic [32:0] reg_read(input logic [AXI_AW-1:0] a);
    logic [1:0] c;
    logic [31:0] d;
    logic hit;
    c = a[CH_LSB +: 2];
    d = '0;
    hit = !a[AXI_AW-1];
    case (a[OFF_W-1:0])
      OFF_SRC: d = src_q[c];
      OFF_DST: d = dst_q[c];
      OFF_CNT: d = 32'(cnt_q[c]);
      OFF_CTRL:
      begin
        d[CB_EN] = en_reg[c];
        d[CB_STG] = stg_reg[c];
        d[CB_TC] = tc_reg[c];
        d[CB_BLOCK] = block_reg[c];
        d[CB_FLYBY] = flyby_reg[c];
        d[CB_SIZE +: 2] = size_reg[c];
      end
      OFF_TRIG: d = 32'(trig_reg[c]);
      default: hit = 1'b0;
    endcase
    return {hit, hit ? d : 32'h0000_0000};
  endfunction

  function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] sz);
    return (sz != SIZE_8) ? {a[31:1], 1'b0} : a;
  endfunction

  // Working and master copies of address and count, one set per channel.
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    dma_reload_reg #(.W(32)) u_src (
      .core_clk(core_clk), .rstn(rstn), .wr_en(wr_src[i]), .wr_data(wval),
      .running(run_reg[i]), .reload(end_ev[i]), .step(step[i]),
      .step_amt(32'h0000_0001 << size_reg[i]), .slave_q(src_q[i])
    );
    dma_reload_reg #(.W(32)) u_dst (
      .core_clk(core_clk), .rstn(rstn), .wr_en(wr_dst[i]), .wr_data(wval),
      .running(run_reg[i]), .reload(end_ev[i]), .step(step[i]),
      .step_amt(32'h0000_0001 << size_reg[i]), .slave_q(dst_q[i])
    );
    dma_reload_reg #(.W(CNT_W)) u_cnt (
      .core_clk(core_clk), .rstn(rstn), .wr_en(wr_cnt[i]), .wr_data(wval[CNT_W-1:0]),
      .running(run_reg[i]), .reload(end_ev[i]), .step(step[i]),
      .step_amt({CNT_W{1'b1}}), .slave_q(cnt_q[i])
    );
  end

  // Register write decode with byte strobes merged over the current value.
  always_comb
  begin
    wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
    wr_cur = reg_read(awaddr_reg);
    wr_hit = wr_cur[32];
    for (int b = 0; b < 4; b++)
      wmask[b*8 +: 8] = {8{wstrb_reg[b]}};
    wval = (wr_cur[31:0] & ~wmask) | (wdata_reg & wmask);
    act = wdata_reg[7:0] & {8{wstrb_reg[0]}};
    for (int i = 0; i < NUM_CH; i++)
    begin
      logic sel;
      sel = wr_fire && wr_hit && (awaddr_reg[CH_LSB +: 2] == 2'(i));
      wr_src[i] = sel && (awaddr_reg[OFF_W-1:0] == OFF_SRC);
      wr_dst[i] = sel && (awaddr_reg[OFF_W-1:0] == OFF_DST);
      wr_cnt[i] = sel && (awaddr_reg[OFF_W-1:0] == OFF_CNT);
      wr_ctl[i] = sel && (awaddr_reg[OFF_W-1:0] == OFF_CTRL);
      wr_trg[i] = sel && (awaddr_reg[OFF_W-1:0] == OFF_TRIG);
      abort_wr[i] = wr_ctl[i] && act[CB_ABORT];
    end
  end

  // Start requests and fixed-priority arbitration.
  always_comb
  begin
    grant = 2'h0;
    grant_ok = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      logic hit;
      hit = 1'b0;
      case (trig_reg[i][TS_SEL_LSB +: 2])
        TS_PIN: hit = !req_s2_reg[i];
        TS_PERIPH: hit = periph_irq[trig_reg[i][TS_IDX_LSB +: 3]];
        TS_USB: hit = usb_req && !block_reg[i];
        default: hit = 1'b0;
      endcase
      pend[i] = en_reg[i] && !tc_reg[i] && (stg_reg[i] || hit);
    end
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (pend[i])
      begin
        grant = 2'(i);
        grant_ok = 1'b1;
      end
    end
  end

  // Sequencing terms of the engine.
  always_comb
  begin
    wait0 = (wait_reg == 3'h0);
    acc_done = (state_reg == S_READ || state_reg == S_WRITE) && wait0 && mem_ready;
    last_cur = (cnt_q[cur_reg] <= CNT_W'(1));
    flyc = flyby_reg[cur_reg];
    abort_cur = (state_reg != S_IDLE) && abort_wr[cur_reg];
    wr_end = (state_reg == S_WRITE) && acc_done && !abort_cur;
    cont = block_reg[cur_reg] && en_reg[cur_reg] && !last_cur;
    go_rd = !abort_cur && (((state_reg == S_RESP) && wait0 && !flyc) || (wr_end && cont && !flyc));
    go_wr = !abort_cur && (((state_reg == S_RESP) && wait0 && flyc) ||
            ((state_reg == S_GAP) && wait0) || (wr_end && cont && flyc));
    for (int i = 0; i < NUM_CH; i++)
    begin
      accept[i] = (state_reg == S_IDLE) && grant_ok && (grant == 2'(i));
      step[i] = wr_end && (cur_reg == 2'(i));
      tc_set[i] = step[i] && last_cur;
      end_ev[i] = tc_set[i] || abort_wr[i];
    end
    nmi_rise = nmi_s2_reg && !nmi_s3_reg;
  end

  // Pin synchronisers.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      req_s1_reg <= '1;
      req_s2_reg <= '1;
      nmi_s1_reg <= 1'b0;
      nmi_s2_reg <= 1'b0;
      nmi_s3_reg <= 1'b0;
    end
    else
    begin
      req_s1_reg <= xfer_request_pin_n;
      req_s2_reg <= req_s1_reg;
      nmi_s1_reg <= nmi_in;
      nmi_s2_reg <= nmi_s1_reg;
      nmi_s3_reg <= nmi_s2_reg;
    end
  end

  // NMI is acknowledged once the engine has gone idle.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      nmi_pend_reg <= 1'b0;
      nmi_ack_reg <= 1'b0;
    end
    else
    begin
      nmi_ack_reg <= nmi_pend_reg && (state_reg == S_IDLE);
      if (nmi_pend_reg && (state_reg == S_IDLE))
        nmi_pend_reg <= 1'b0;
      if (nmi_rise)
        nmi_pend_reg <= 1'b1;
    end
  end

  // Channel control flags.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      en_reg <= '0;
      stg_reg <= '0;
      tc_reg <= '0;
      block_reg <= '0;
      flyby_reg <= '0;
      run_reg <= '0;
      irq_reg <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        size_reg[i] <= SIZE_8;
        trig_reg[i] <= TRIG_RST;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        irq_reg[i] <= tc_set[i];
        if (wr_ctl[i])
        begin
          en_reg[i] <= wval[CB_EN];
          block_reg[i] <= wval[CB_BLOCK];
          flyby_reg[i] <= wval[CB_FLYBY];
          size_reg[i] <= wval[CB_SIZE +: 2];
        end
        if (nmi_rise || abort_wr[i])
          en_reg[i] <= 1'b0;
        if (accept[i] || abort_wr[i])
          stg_reg[i] <= 1'b0;
        if (wr_ctl[i] && act[CB_STG])
          stg_reg[i] <= 1'b1;
        if (wr_ctl[i] && act[CB_TC])
          tc_reg[i] <= 1'b0;
        if (tc_set[i])
          tc_reg[i] <= 1'b1;
        if (accept[i])
          run_reg[i] <= 1'b1;
        if (end_ev[i])
          run_reg[i] <= 1'b0;
        if (wr_trg[i])
          trig_reg[i] <= wval[7:0];
      end
    end
  end

  // Transfer engine.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_reg <= S_IDLE;
      cur_reg <= 2'h0;
      wait_reg <= 3'h0;
      data_reg <= 32'h0000_0000;
      mem_out_reg <= '0;
      strobe_n_reg <= 1'b1;
      hold_reg <= 1'b0;
      ack_n_reg <= '1;
      tc_n_reg <= '1;
    end
    else
    begin
      strobe_n_reg <= 1'b1;
      tc_n_reg <= '1;
      if (abort_cur)
      begin
        state_reg <= S_IDLE;
        mem_out_reg.req <= 1'b0;
        ack_n_reg <= '1;
        hold_reg <= 1'b0;
      end
      else if (go_rd || go_wr)
      begin
        state_reg <= go_wr ? S_WRITE : S_READ;
        wait_reg <= ACC_WAIT;
        strobe_n_reg <= 1'b0;
        mem_out_reg.req <= 1'b1;
        mem_out_reg.we <= go_wr && !flyc;
        mem_out_reg.flyby <= flyc;
        mem_out_reg.size <= size_reg[cur_reg];
        // A block transfer that chains from a write adds the step itself; the source working copy steps in the same clock.
        mem_out_reg.addr <= align((go_wr && !flyc) ? dst_q[cur_reg] : src_q[cur_reg] +
                                  (wr_end ? (32'h0000_0001 << size_reg[cur_reg]) : 32'h0000_0000),
                                  size_reg[cur_reg]);
        mem_out_reg.wdata <= data_reg;
        ack_n_reg[cur_reg] <= 1'b0;
      end
      else
      begin
        case (state_reg)
          S_IDLE:
            if (grant_ok)
            begin
              cur_reg <= grant;
              wait_reg <= RESP_WAIT;
              state_reg <= S_RESP;
              hold_reg <= 1'b1;
            end
          S_RESP, S_GAP:
            wait_reg <= wait_reg - 3'h1;
          S_READ:
            if (acc_done)
            begin
              data_reg <= mem_rdata;
              mem_out_reg.req <= 1'b0;
              wait_reg <= GAP_WAIT;
              state_reg <= S_GAP;
            end
            else if (!wait0)
              wait_reg <= wait_reg - 3'h1;
          S_WRITE:
          begin
            if (!strobe_n_reg && last_cur)
              tc_n_reg[cur_reg] <= 1'b0;
            if (acc_done)
            begin
              mem_out_reg.req <= 1'b0;
              ack_n_reg <= '1;
              state_reg <= S_IDLE;
              hold_reg <= 1'b0;
            end
            else if (!wait0)
              wait_reg <= wait_reg - 3'h1;
          end
          default:
            state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // AXI4-Lite write channel; address and data are taken in either order.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        awaddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel; the answer follows the address by one clock.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      logic [32:0] rd;
      rd = reg_read(s_axi_araddr);
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd[31:0];
      rresp_reg <= rd[32] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign xfer_ack_pin_n = ack_n_reg;
  assign terminal_count_n = tc_n_reg;
  assign nmi_ack = nmi_ack_reg;
  assign mem_out = mem_out_reg;
  assign bus_cycle_start_strobe_n = strobe_n_reg;
  assign cpu_hold = hold_reg;
  assign transfer_end_interrupt = irq_reg;
endmodule // dma_ctrl

/* pkg/dma_pkg.sv */
/*
  Shared constants, types and register map of the four-channel DMA control block.
  Assumes a single bus clock domain and an AXI4-Lite register port with 32-bit data.
*/
package dma_pkg;
  localparam int NUM_CH = 4;
  localparam int AXI_AW = 8;
  localparam int CH_LSB = 5;
  localparam int OFF_W = 5;
  // Register offsets inside one channel window; channel n sits at n * 32'h20.
  localparam logic [OFF_W-1:0] OFF_SRC = 5'h00;
  localparam logic [OFF_W-1:0] OFF_DST = 5'h04;
  localparam logic [OFF_W-1:0] OFF_CNT = 5'h08;
  localparam logic [OFF_W-1:0] OFF_CTRL = 5'h0C;
  localparam logic [OFF_W-1:0] OFF_TRIG = 5'h10;
  // Fields of channel_control_reg.
  localparam int CB_EN = 0;
  localparam int CB_STG = 1;
  localparam int CB_ABORT = 2;
  localparam int CB_TC = 3;
  localparam int CB_BLOCK = 4;
  localparam int CB_FLYBY = 5;
  localparam int CB_SIZE = 6;
  // Fields of trigger_select_reg.
  localparam int TS_SEL_LSB = 0;
  localparam int TS_IDX_LSB = 4;
  localparam logic [1:0] TS_PIN = 2'h0;
  localparam logic [1:0] TS_PERIPH = 2'h1;
  localparam logic [1:0] TS_USB = 2'h2;
  // Transfer sizes.
  localparam logic [1:0] SIZE_8 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_32 = 2'h2;
  // Reset values.
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [7:0] TRIG_RST = 8'h00;
  // Cycle figures and the wait counts derived from them.
  localparam int RESP_CLKS = 4;
  localparam int GAP_CLKS = 2;
  localparam int ACC_MIN_CLKS = 2;
  localparam logic [2:0] RESP_WAIT = 3'(RESP_CLKS - 1);
  localparam logic [2:0] GAP_WAIT = 3'(GAP_CLKS - 1);
  localparam logic [2:0] ACC_WAIT = 3'(ACC_MIN_CLKS - 1);
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_RESP = 5'h02,
    S_READ = 5'h04,
    S_GAP = 5'h08,
    S_WRITE = 5'h10
  } dma_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic flyby;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_bus_s;
endpackage

/* rtl/dma_reload_reg.sv */
/*
  Two-stage master and working register for one address or count of a channel.
  Assumes the caller pulses reload at the end of a transfer and step after each unit written.
*/
`timescale 1ns/100ps
module dma_reload_reg
  import dma_pkg::*;
#(
  parameter int W = 32
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Software write.
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // Transfer control.
  input wire logic running,
  input wire logic reload,
  input wire logic step,
  input wire logic [W-1:0] step_amt,
  // Working copy.
  output logic [W-1:0] slave_q
);
  logic [W-1:0] master_reg;
  logic [W-1:0] slave_reg;

  // Both copies start equal.
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      master_reg <= W'(ADDR_RST);
    else if (wr_en)
      master_reg <= wr_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      slave_reg <= W'(ADDR_RST);
    else if (wr_en && !running)
      slave_reg <= wr_data;
    else if (reload)
      slave_reg <= master_reg;
    else if (step)
      slave_reg <= slave_reg + step_amt;
  end

  assign slave_q = slave_reg;
endmodule // dma_reload_reg

/* dv/dma_mem_model.sv */
/* Memory and I/O target model for the DMA control block's system bus.
   Assumes the bus and the access strobe are driven from core_clk. */
`timescale 1ns/100ps
module dma_mem_model
  import dma_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // Bus from the block.
  input mem_bus_s mem_out,
  input wire logic bus_cycle_start_strobe_n,
  input wire logic [1:0] wait_cfg,
  output logic mem_ready,
  output logic [31:0] mem_rdata,
  // Record of write accesses.
  output logic [31:0] last_waddr,
  output logic [31:0] last_wdata,
  output logic [7:0] wr_cnt
);
  logic [1:0] wait_reg;
  logic [31:0] junk_reg;
  // Ready comes after the chosen number of extra cycles; data churns when not ready.
  assign mem_ready = mem_out.req && bus_cycle_start_strobe_n && wait_reg >= wait_cfg;
  assign mem_rdata = mem_ready ? ~mem_out.addr : junk_reg;
  always_ff @(posedge core_clk)
  begin
    junk_reg <= rstn ? junk_reg + 32'h3C5A_0F01 : 32'h0;
    wait_reg <= (!bus_cycle_start_strobe_n || wait_reg == 2'h3) ? 2'h0 : wait_reg + 2'h1;
    if (!rstn)
      wr_cnt <= 8'h00;
    else if (!bus_cycle_start_strobe_n && (mem_out.we || mem_out.flyby))
    begin
      wr_cnt <= wr_cnt + 8'h01;
      last_waddr <= mem_out.addr;
      last_wdata <= mem_out.wdata;
    end
  end
endmodule // dma_mem_model

/* dv/dma_ctrl_checker.sv */
/* Port assertions for the DMA control block.
   Assumes it is bound to dma_ctrl and sees only its ports. */
`timescale 1ns/100ps
module dma_ctrl_checker
  import dma_pkg::*;
(
  // Watched ports.
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [NUM_CH-1:0] terminal_count_n,
  input wire logic [NUM_CH-1:0] xfer_ack_pin_n,
  input wire logic [NUM_CH-1:0] transfer_end_interrupt,
  input mem_bus_s mem_out,
  input wire logic bus_cycle_start_strobe_n,
  input wire logic cpu_hold,
  input wire logic nmi_ack
);
  logic [NUM_CH-1:0] tc_seen_reg;
  // Remembers which channel pulsed terminal count until its write access ends.
  always_ff @(posedge core_clk)
  begin
    if (!rstn || (terminal_count_n == 4'hF && !mem_out.req))
      tc_seen_reg <= '0;
    else if (terminal_count_n != 4'hF)
      tc_seen_reg <= ~terminal_count_n;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_tc_one: assert property (terminal_count_n != 4'hF |=> terminal_count_n == 4'hF)
    else $error("terminal count held too long");
  a_tc_place: assert property (terminal_count_n != 4'hF |->
    !$past(bus_cycle_start_strobe_n) && mem_out.req && (mem_out.we || mem_out.flyby))
    else $error("terminal count misplaced");
  a_end_irq: assert property ($fell(mem_out.req) && ($past(mem_out.we) ||
    $past(mem_out.flyby)) |-> transfer_end_interrupt == tc_seen_reg)
    else $error("transfer end interrupt missing");
  a_resp_four: assert property ($rose(cpu_hold) |-> !mem_out.req [*4])
    else $error("request answered too soon");
  a_access_two: assert property ($rose(mem_out.req) |=> mem_out.req)
    else $error("access shorter than two clocks");
  a_gap_two: assert property ($fell(mem_out.req) && cpu_hold && !$past(mem_out.we) &&
    !$past(mem_out.flyby) |-> !mem_out.req [*2] ##1 mem_out.req)
    else $error("read to write gap wrong");
  a_addr_align: assert property (mem_out.req && mem_out.size != SIZE_8 |-> !mem_out.addr[0])
    else $error("odd address on wide access");
  a_bus_owned: assert property (mem_out.req || xfer_ack_pin_n != 4'hF |-> cpu_hold)
    else $error("bus used without holding the cpu");
  a_nmi_idle: assert property (nmi_ack |-> !cpu_hold)
    else $error("nmi acknowledged during transfer");
endmodule // dma_ctrl_checker

bind dma_ctrl dma_ctrl_checker u_chk (.core_clk, .rstn, .terminal_count_n, .xfer_ack_pin_n,
  .transfer_end_interrupt, .mem_out, .bus_cycle_start_strobe_n, .cpu_hold, .nmi_ack);

/* dv/tb_dma_start_reload_terminal_count.sv */
/* Self-checking bench for the DMA control block over its AXI4-Lite port.
   Assumes the memory model answers the system bus. */
`timescale 1ns/100ps
module tb_dma_start_reload_terminal_count
  import dma_pkg::*;
;
  logic core_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, periph_irq, wr_cnt;
  logic [31:0] s_axi_wdata, s_axi_rdata, mem_rdata, last_waddr, last_wdata;
  logic [3:0] s_axi_wstrb, xfer_request_pin_n, xfer_ack_pin_n, terminal_count_n;
  logic [3:0] transfer_end_interrupt;
  logic [1:0] s_axi_bresp, s_axi_rresp, mem_wait;
  logic usb_req, nmi_in, nmi_ack, mem_ready, bus_cycle_start_strobe_n, cpu_hold;
  mem_bus_s mem_out;
  int checks, miscompares;
  dma_ctrl dut (.core_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .xfer_request_pin_n, .xfer_ack_pin_n, .terminal_count_n, .periph_irq, .usb_req,
    .nmi_in, .nmi_ack, .mem_out, .mem_rdata, .mem_ready, .bus_cycle_start_strobe_n, .cpu_hold,
    .transfer_end_interrupt);
  dma_mem_model mem (.core_clk, .rstn, .mem_out, .bus_cycle_start_strobe_n, .wait_cfg(mem_wait),
    .mem_ready, .mem_rdata, .last_waddr, .last_wdata, .wr_cnt);
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic test_done;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    cmp(32'(s_axi_bresp), 32'(e));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    cmp(s_axi_rdata, e);
    cmp(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
  endtask
  // Waits for an end interrupt (0-3), a low acknowledge (4-7) or the nmi acknowledge (8).
  task automatic wait_ev(input int k);
    int n;
    n = 0;
    while (!(k < 4 ? transfer_end_interrupt[k] === 1'b1 : k < 8 ?
      xfer_ack_pin_n[k-4] === 1'b0 : nmi_ack === 1'b1) && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    cmp(32'(n < 400), 32'h1);
  endtask
  initial
  begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, periph_irq, usb_req, nmi_in, mem_wait} = '0;
    s_axi_wstrb = 4'hF;
    xfer_request_pin_n = 4'hF;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rd({3'h0, OFF_SRC}, 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    wr({3'h0, OFF_SRC}, 32'h101, RESP_OKAY);
    wr({3'h0, OFF_DST}, 32'h200, RESP_OKAY);
    wr({3'h0, OFF_CNT}, 32'h2, RESP_OKAY);
    rd({3'h0, OFF_SRC}, 32'h101, RESP_OKAY);
    wr({3'h0, OFF_CTRL}, 32'h93, RESP_OKAY);
    wr({3'h0, OFF_SRC}, 32'h400, RESP_OKAY);
    wait_ev(0);
    cmp(last_wdata, ~32'h104);
    cmp(last_waddr, 32'h204);
    cmp(32'(wr_cnt), 32'h2);
    rd({3'h0, OFF_SRC}, 32'h400, RESP_OKAY);
    wr({3'h0, OFF_CTRL}, 32'h93, RESP_OKAY);
    repeat (30) @(posedge core_clk);
    cmp(32'(wr_cnt), 32'h2);
    wr({3'h0, OFF_CTRL}, 32'h9B, RESP_OKAY);
    wait_ev(0);
    cmp(32'(wr_cnt), 32'h4);
    wr({3'h1, OFF_DST}, 32'h300, RESP_OKAY);
    xfer_request_pin_n[1] <= 1'b0;
    repeat (20) @(posedge core_clk);
    cmp(32'(xfer_ack_pin_n), 32'hF);
    wr({3'h1, OFF_CTRL}, 32'h1, RESP_OKAY);
    wait_ev(5);
    xfer_request_pin_n[1] <= 1'b1;
    wait_ev(1);
    cmp(last_waddr, 32'h300);
    wr({3'h2, OFF_SRC}, 32'h500, RESP_OKAY);
    wr({3'h2, OFF_TRIG}, 32'h51, RESP_OKAY);
    wr({3'h2, OFF_CTRL}, 32'h21, RESP_OKAY);
    wr({3'h3, OFF_DST}, 32'h700, RESP_OKAY);
    wr({3'h3, OFF_TRIG}, 32'h2, RESP_OKAY);
    wr({3'h3, OFF_CTRL}, 32'h1, RESP_OKAY);
    periph_irq[5] <= 1'b1;
    usb_req <= 1'b1;
    wait_ev(6);
    cmp(32'(xfer_ack_pin_n[3]), 32'h1);
    periph_irq[5] <= 1'b0;
    wait_ev(7);
    usb_req <= 1'b0;
    wait_ev(3);
    cmp(32'(wr_cnt), 32'h7);
    cmp(last_waddr, 32'h700);
    mem_wait <= 2'h3;
    wr({3'h0, OFF_CNT}, 32'h8, RESP_OKAY);
    wr({3'h0, OFF_CTRL}, 32'h9B, RESP_OKAY);
    wr({3'h0, OFF_CTRL}, 32'h4, RESP_OKAY);
    repeat (2) @(posedge core_clk);
    cmp(32'(cpu_hold), 32'h0);
    rd({3'h0, OFF_CNT}, 32'h8, RESP_OKAY);
    wr({3'h0, OFF_CTRL}, 32'h9B, RESP_OKAY);
    wait_ev(4);
    nmi_in <= 1'b1;
    wait_ev(8);
    nmi_in <= 1'b0;
    rd({3'h0, OFF_CTRL}, 32'h90, RESP_OKAY);
    test_done();
  end
  initial
  begin
    #100us;
    miscompares++;
    test_done();
  end
endmodule // tb_dma_start_reload_terminal_count
